/* File: hw/mrm_pkg.sv */
/*
  Shared constants, types and helper functions for the multi-register
  move and peripheral byte move sequencer.
  Assumes a 32-bit address space and a 16-entry register file in which
  indices 0-7 are data_reg_n and 8-15 are addr_reg_n.
*/
package mrm_pkg;

  // ------------------------------------------------------------------
  // Opcode fields
  // ------------------------------------------------------------------
  localparam logic [3:0] MRM_OP_MRM_TOP = 4'h4;
  localparam logic [2:0] MRM_OP_MRM_MID = 3'h1;
  localparam logic [3:0] MRM_OP_PBM_TOP = 4'h0;
  localparam logic [2:0] MRM_OP_PBM_MODE = 3'h1;

  // Effective address mode and register codes.
  localparam logic [2:0] MRM_EA_IND = 3'h2;
  localparam logic [2:0] MRM_EA_POSTINC = 3'h3;
  localparam logic [2:0] MRM_EA_PREDEC = 3'h4;
  localparam logic [2:0] MRM_EA_DISP = 3'h5;
  localparam logic [2:0] MRM_EA_INDEX = 3'h6;
  localparam logic [2:0] MRM_EA_EXT = 3'h7;
  localparam logic [2:0] MRM_EXT_ABS_W = 3'h0;
  localparam logic [2:0] MRM_EXT_ABS_L = 3'h1;
  localparam logic [2:0] MRM_EXT_PC_IDX = 3'h3;

  // ------------------------------------------------------------------
  // Bus sizes, lengths and counts
  // ------------------------------------------------------------------
  localparam logic [1:0] MRM_SZ_BYTE = 2'h0;
  localparam logic [1:0] MRM_SZ_WORD = 2'h1;
  localparam logic [1:0] MRM_SZ_LONG = 2'h2;
  localparam logic [31:0] MRM_LEN_WORD = 32'h0000_0002;
  localparam logic [31:0] MRM_LEN_LONG = 32'h0000_0004;
  localparam logic [31:0] MRM_PBM_STEP = 32'h0000_0002;
  localparam logic [2:0] MRM_PBM_CNT_W = 3'h2;
  localparam logic [2:0] MRM_PBM_CNT_L = 3'h4;

  typedef enum logic [1:0] {
    MRM_IDLE,
    MRM_LOAD,
    MRM_MEM,
    MRM_AREG
  } mrm_state_t;

  // Sign-extends a 16-bit word to a long word.
  function automatic logic [31:0] sext16(input logic [15:0] w);
    sext16 = {{16{w[15]}}, w};
  endfunction

  // Operand length in bytes for the size bit.
  function automatic logic [31:0] op_len(input logic long_sz);
    op_len = long_sz ? MRM_LEN_LONG : MRM_LEN_WORD;
  endfunction

endpackage

/* File: hw/mrm_decode.sv */
/*
  Opcode decoder for the two move instructions.
  Purely combinational; the caller presents the first opcode word.
*/
`timescale 1ns/1ps
`default_nettype none
module mrm_decode (
  input wire logic [15:0] op_word,
  output logic is_mrm,
  output logic is_pbm,
  output logic legal,
  output logic to_reg,
  output logic long_sz,
  output logic predec,
  output logic postinc
);
  logic [2:0] mode;
  logic [2:0] rg;
  logic st_ok;
  logic ld_ok;

  // Field extraction and instruction recognition.
  assign mode = op_word[5:3];
  assign rg = op_word[2:0];
  assign is_mrm = op_word[15:12] == mrm_pkg::MRM_OP_MRM_TOP
                  && op_word[11]
                  && op_word[9:7] == mrm_pkg::MRM_OP_MRM_MID;
  assign is_pbm = op_word[15:12] == mrm_pkg::MRM_OP_PBM_TOP
                  && op_word[8]
                  && op_word[5:3] == mrm_pkg::MRM_OP_PBM_MODE;

  // Accepted modes for stores and for loads.
  always_comb begin
    st_ok = 1'b0;
    ld_ok = 1'b0;
    case (mode)
      mrm_pkg::MRM_EA_IND, mrm_pkg::MRM_EA_DISP,
      mrm_pkg::MRM_EA_INDEX: begin
        st_ok = 1'b1;
        ld_ok = 1'b1;
      end
      mrm_pkg::MRM_EA_PREDEC: st_ok = 1'b1;
      mrm_pkg::MRM_EA_POSTINC: ld_ok = 1'b1;
      mrm_pkg::MRM_EA_EXT: begin
        st_ok = rg <= mrm_pkg::MRM_EXT_ABS_L;
        ld_ok = rg <= mrm_pkg::MRM_EXT_PC_IDX;
      end
      default: begin
        st_ok = 1'b0;
        ld_ok = 1'b0;
      end
    endcase
  end

  // Direction and size for both instructions; sequence selection for the multi-register move only.
  assign to_reg = is_mrm ? op_word[10] : ~op_word[7];
  assign long_sz = op_word[6];
  assign predec = is_mrm && mode == mrm_pkg::MRM_EA_PREDEC;
  assign postinc = is_mrm && mode == mrm_pkg::MRM_EA_POSTINC;
  assign legal = is_pbm || (is_mrm && (to_reg ? ld_ok : st_ok));
endmodule
`default_nettype wire

/* File: hw/mrm_pick.sv */
/*
  Finds the lowest set bit of the remaining register selection mask.
  Combinational; the caller maps the bit to a register index.
*/
`timescale 1ns/1ps
`default_nettype none
module mrm_pick (
  input wire logic [15:0] mask,
  output logic any,
  output logic [3:0] idx
);
  // Scans from the top so the lowest set bit wins.
  always_comb begin
    any = |mask;
    idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (mask[i]) begin
        idx = 4'(i);
      end
    end
  end
endmodule
`default_nettype wire

/* File: hw/mrm_seq.sv */
/*
  Sequencer for the multi-register move and the peripheral byte move.
  Assumes an address unit that supplies ea_addr with start: the computed
  address for control modes, the addressing register's value for the
  predecrement, postincrement and peripheral forms. The register file
  reads combinationally; memory answers each request with mem_ready.
*/
`timescale 1ns/1ps
`default_nettype none
module mrm_seq (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [15:0] op_word,
  input wire logic [15:0] ext_word,
  input wire logic [31:0] ea_addr,
  input wire logic legacy_store,
  output logic [3:0] rf_raddr,
  input wire logic [31:0] rf_rdata,
  output logic rf_we,
  output logic [3:0] rf_waddr,
  output logic [31:0] rf_wdata,
  output logic mem_req,
  output logic mem_we,
  output logic [1:0] mem_size,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ready,
  input wire logic [31:0] mem_rdata,
  output logic busy,
  output logic done,
  output logic illegal
);

  // ------------------------------------------------------------------
  // Decode and mask scan
  // ------------------------------------------------------------------
  logic dec_mrm, dec_pbm, dec_legal, dec_rd, dec_long, dec_pre, dec_post;
  logic pick_any, is_areg, take;
  logic [3:0] pick_idx, cur_d;
  logic [31:0] len, st_val;

  mrm_pkg::mrm_state_t st_q;
  logic mrm_q, rd_q, long_q, pre_q, post_q, legacy_q, skip_q;
  logic [2:0] areg_q, dreg_q, cnt_q;
  logic [3:0] cur_q, rf_waddr_q;
  logic [15:0] rem_q, hi_q;
  logic [31:0] addr_q, base_q, sh_q, wdata_q, rf_wdata_q;
  logic [1:0] size_q;
  logic rf_we_q, done_q, illegal_q;
  mrm_decode u_dec (
    .op_word(op_word),
    .is_mrm(dec_mrm),
    .is_pbm(dec_pbm),
    .legal(dec_legal),
    .to_reg(dec_rd),
    .long_sz(dec_long),
    .predec(dec_pre),
    .postinc(dec_post)
  );
  mrm_pick u_pick (
    .mask(rem_q),
    .any(pick_any),
    .idx(pick_idx)
  );
  // Maps a mask bit to a register, flags the addressing one, picks data.
  assign cur_d = pre_q ? 4'hf - pick_idx : pick_idx;
  assign is_areg = cur_d == {1'b1, areg_q};
  assign len = mrm_pkg::op_len(long_q);
  assign take = st_q == mrm_pkg::MRM_IDLE && start;
  assign st_val = (pre_q && is_areg) ? (legacy_q ? base_q : base_q - len)
                                     : rf_rdata;

  // ------------------------------------------------------------------
  // Control sequence
  // ------------------------------------------------------------------
  // Steps through the selected registers or peripheral bytes.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= mrm_pkg::MRM_IDLE;
    end else begin
      case (st_q)
        mrm_pkg::MRM_IDLE: begin
          if (take && dec_legal) begin
            st_q <= mrm_pkg::MRM_LOAD;
          end
        end
        mrm_pkg::MRM_LOAD: begin
          if (mrm_q ? pick_any : cnt_q != 3'h0) begin
            st_q <= mrm_pkg::MRM_MEM;
          end else if (mrm_q && (pre_q || post_q)) begin
            st_q <= mrm_pkg::MRM_AREG;
          end else begin
            st_q <= mrm_pkg::MRM_IDLE;
          end
        end
        mrm_pkg::MRM_MEM: begin
          if (mem_ready) begin
            st_q <= mrm_pkg::MRM_LOAD;
          end
        end
        mrm_pkg::MRM_AREG: st_q <= mrm_pkg::MRM_IDLE;
        default: st_q <= mrm_pkg::MRM_IDLE;
      endcase
    end
  end
  // Captures the decoded instruction when a legal one is taken.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mrm_q <= 1'b0;
      rd_q <= 1'b0;
      long_q <= 1'b0;
      pre_q <= 1'b0;
      post_q <= 1'b0;
      legacy_q <= 1'b0;
      areg_q <= 3'h0;
      dreg_q <= 3'h0;
      base_q <= 32'h0;
    end else if (take && dec_legal) begin
      mrm_q <= dec_mrm;
      rd_q <= dec_rd;
      long_q <= dec_long;
      pre_q <= dec_pre;
      post_q <= dec_post;
      legacy_q <= legacy_store;
      areg_q <= op_word[2:0];
      dreg_q <= op_word[11:9];
      base_q <= ea_addr;
    end
  end
  // Keeps the remaining mask and the byte count.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rem_q <= 16'h0;
      cnt_q <= 3'h0;
      cur_q <= 4'h0;
      skip_q <= 1'b0;
    end else if (take && dec_legal) begin
      rem_q <= dec_mrm ? ext_word : 16'h0;
      cnt_q <= dec_long ? mrm_pkg::MRM_PBM_CNT_L
                        : mrm_pkg::MRM_PBM_CNT_W;
    end else if (st_q == mrm_pkg::MRM_LOAD && mrm_q && pick_any) begin
      rem_q[pick_idx] <= 1'b0;
      cur_q <= cur_d;
      skip_q <= post_q && is_areg;
    end else if (st_q == mrm_pkg::MRM_MEM && mem_ready && !mrm_q) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end

  // ------------------------------------------------------------------
  // Addressing
  // ------------------------------------------------------------------
  // Forms the first address and steps it after each transfer, or before each one for predecrement.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      addr_q <= 32'h0;
    end else if (take && dec_legal) begin
      addr_q <= dec_mrm ? ea_addr
                        : ea_addr + mrm_pkg::sext16(ext_word);
    end else if (st_q == mrm_pkg::MRM_LOAD && mrm_q && pick_any
                 && pre_q) begin
      addr_q <= addr_q - len;
    end else if (st_q == mrm_pkg::MRM_MEM && mem_ready) begin
      if (!mrm_q) begin
        addr_q <= addr_q + mrm_pkg::MRM_PBM_STEP;
      end else if (!pre_q) begin
        addr_q <= addr_q + len;
      end
    end
  end

  // ------------------------------------------------------------------
  // Data paths
  // ------------------------------------------------------------------
  // Peripheral byte shifter, most significant byte at the top.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sh_q <= 32'h0;
      hi_q <= 16'h0;
    end else if (take && dec_legal) begin
      sh_q <= dec_long ? rf_rdata : {rf_rdata[15:0], 16'h0};
      hi_q <= rf_rdata[31:16];
    end else if (st_q == mrm_pkg::MRM_MEM && mem_ready && !mrm_q) begin
      sh_q <= {sh_q[23:0], rd_q ? mem_rdata[7:0] : 8'h0};
    end
  end

  // Store data and access size for the next memory request.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wdata_q <= 32'h0;
      size_q <= mrm_pkg::MRM_SZ_BYTE;
    end else if (st_q == mrm_pkg::MRM_LOAD && !mrm_q) begin
      wdata_q <= {24'h0, sh_q[31:24]};
      size_q <= mrm_pkg::MRM_SZ_BYTE;
    end else if (st_q == mrm_pkg::MRM_LOAD && pick_any) begin
      size_q <= long_q ? mrm_pkg::MRM_SZ_LONG
                       : mrm_pkg::MRM_SZ_WORD;
      wdata_q <= long_q ? st_val : {16'h0, st_val[15:0]};
    end
  end

  // Register file writes: loads, peripheral result, address update.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rf_we_q <= 1'b0;
      rf_waddr_q <= 4'h0;
      rf_wdata_q <= 32'h0;
    end else begin
      rf_we_q <= 1'b0;
      if (st_q == mrm_pkg::MRM_MEM && mem_ready && mrm_q && rd_q
          && !skip_q) begin
        rf_we_q <= 1'b1;
        rf_waddr_q <= cur_q;
        rf_wdata_q <= long_q ? mem_rdata
                             : mrm_pkg::sext16(mem_rdata[15:0]);
      end else if (st_q == mrm_pkg::MRM_LOAD && !mrm_q && rd_q
                   && cnt_q == 3'h0) begin
        rf_we_q <= 1'b1;
        rf_waddr_q <= {1'b0, dreg_q};
        rf_wdata_q <= long_q ? sh_q : {hi_q, sh_q[15:0]};
      end else if (st_q == mrm_pkg::MRM_AREG) begin
        rf_we_q <= 1'b1;
        rf_waddr_q <= {1'b1, areg_q};
        rf_wdata_q <= addr_q;
      end
    end
  end

  // Completion and rejection pulses; no flag register is touched.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      done_q <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      illegal_q <= take && !dec_legal;
      done_q <= st_q == mrm_pkg::MRM_AREG
                || (st_q == mrm_pkg::MRM_LOAD && !(pre_q || post_q)
                    && (mrm_q ? !pick_any : cnt_q == 3'h0));
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign rf_raddr = st_q == mrm_pkg::MRM_IDLE ? {1'b0, op_word[11:9]}
                                              : cur_d;
  assign rf_we = rf_we_q;
  assign rf_waddr = rf_waddr_q;
  assign rf_wdata = rf_wdata_q;
  assign mem_req = st_q == mrm_pkg::MRM_MEM;
  assign mem_we = !rd_q;
  assign mem_size = size_q;
  assign mem_addr = addr_q;
  assign mem_wdata = wdata_q;
  assign busy = st_q != mrm_pkg::MRM_IDLE;
  assign done = done_q;
  assign illegal = illegal_q;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  property p_size;
    mem_req && mrm_q |-> mem_size == (long_q ? 2'h2 : 2'h1);
  endproperty
  a_size: assert property (p_size) else $error("Bad transfer size.");
  property p_sext;
    st_q == mrm_pkg::MRM_MEM && mem_ready && mrm_q && rd_q && !long_q
      && !skip_q |=> rf_we && rf_wdata == {{16{$past(mem_rdata[15])}},
                                           $past(mem_rdata[15:0])};
  endproperty
  a_sext: assert property (p_sext) else $error("Word not extended.");
  property p_step_up;
    mem_req && mem_ready && mrm_q && !pre_q
      |=> mem_addr == $past(mem_addr) + (long_q ? 32'h4 : 32'h2);
  endproperty
  a_step_up: assert property (p_step_up) else $error("Bad step up.");
  property p_step_down;
    st_q == mrm_pkg::MRM_LOAD && mrm_q && pre_q && pick_any
      |=> mem_req && mem_addr == $past(mem_addr) - (long_q ? 32'h4 : 32'h2);
  endproperty
  a_step_down: assert property (p_step_down) else $error("Bad step down.");
  property p_pre_wb;
    st_q == mrm_pkg::MRM_AREG && pre_q
      |=> rf_we && rf_wdata == $past(addr_q) && done;
  endproperty
  a_pre_wb: assert property (p_pre_wb) else $error("Bad final address.");
  property p_post_wb;
    st_q == mrm_pkg::MRM_AREG && post_q |=> rf_waddr == {1'b1, areg_q};
  endproperty
  a_post_wb: assert property (p_post_wb) else $error("Bad writeback reg.");
  property p_self_skip;
    mem_req && mem_ready && post_q && cur_q == {1'b1, areg_q} |=> !rf_we;
  endproperty
  a_self_skip: assert property (p_self_skip) else $error("Self load kept.");
  property p_pbm_step;
    mem_req && mem_ready && !mrm_q |=> mem_addr == $past(mem_addr) + 32'h2;
  endproperty
  a_pbm_step: assert property (p_pbm_step) else $error("Bad byte step.");
  property p_reject;
    take && dec_mrm && (dec_pre && dec_rd || dec_post && !dec_rd)
      |=> illegal && !busy;
  endproperty
  a_reject: assert property (p_reject) else $error("Bad mode taken.");
  c_pbm: cover property (take && dec_pbm ##[1:40] done);
  c_pre: cover property (take && dec_pre && dec_legal ##[1:80] done);
  c_post: cover property (take && dec_post && dec_legal ##[1:80] done);
endmodule
`default_nettype wire

/* File: verif/mrm_bus_model.sv */
/*
  Far-side model: register file read port and memory port of the sequencer.
  Assumes the bench sets slow before each start; reads are combinational.
*/
`timescale 1ns/1ps
`default_nettype none
module mrm_bus_model (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic [3:0] rf_raddr,
  output logic [31:0] rf_rdata,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic mem_ready,
  output logic [31:0] mem_rdata
);
  // ------------------------------------------------------------------
  // Wait states and idle noise
  // ------------------------------------------------------------------
  logic [1:0] wait_q;
  logic [31:0] noise_q;

  // A slow memory answers on the third cycle of a request.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wait_q <= 2'h0;
      noise_q <= 32'h0;
    end else begin
      wait_q <= (mem_req && !mem_ready) ? wait_q + 2'h1 : 2'h0;
      noise_q <= noise_q + 32'h1357_9bdf;
    end
  end

  // Read data is valid only with ready; otherwise it changes every cycle.
  assign mem_ready = mem_req && (!slow || wait_q == 2'h2);
  assign mem_rdata = mem_ready ?
    {~mem_addr[15:0], mem_addr[15:0] ^ 16'h8001} : noise_q;
  assign rf_rdata = {4'h9, rf_raddr, 8'h5a, 4'h3, rf_raddr, 8'hc6};
endmodule
`default_nettype wire

/* File: verif/mrm_seq_tb_top.sv */
/*
  Self-checking bench for the sequencer: the driver queues expected bus
  and register results, a monitor compares them as they appear.
  Assumes the far-side model for register file and memory.
*/
`timescale 1ns/1ps
`default_nettype none
module mrm_seq_tb_top;
  typedef struct packed {
    logic r;
    logic we;
    logic [1:0] sz;
    logic [31:0] a;
    logic [31:0] d;
  } mrm_note_t;

  logic mclk, reset_n, start, legacy_store, slow, rf_we, mem_req, mem_we;
  logic busy, done, illegal, mem_ready;
  logic [15:0] op_word, ext_word;
  logic [31:0] ea_addr, rf_rdata, rf_wdata, mem_addr, mem_wdata, mem_rdata;
  logic [3:0] rf_raddr, rf_waddr;
  logic [1:0] mem_size;
  mrm_note_t note_q[$];
  mrm_note_t exp_n;
  int fails = 0, check_count = 0, cycles = 0, seed = 83767, i, c;

  mrm_seq dut (.mclk(mclk), .reset_n(reset_n), .start(start),
    .op_word(op_word), .ext_word(ext_word), .ea_addr(ea_addr),
    .legacy_store(legacy_store), .rf_raddr(rf_raddr), .rf_rdata(rf_rdata),
    .rf_we(rf_we), .rf_waddr(rf_waddr), .rf_wdata(rf_wdata),
    .mem_req(mem_req), .mem_we(mem_we), .mem_size(mem_size),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ready(mem_ready),
    .mem_rdata(mem_rdata), .busy(busy), .done(done), .illegal(illegal));

  mrm_bus_model bus_model (.mclk(mclk), .reset_n(reset_n), .slow(slow),
    .rf_raddr(rf_raddr), .rf_rdata(rf_rdata), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ready(mem_ready), .mem_rdata(mem_rdata));

  // ------------------------------------------------------------------
  // Helpers and compare tasks
  // ------------------------------------------------------------------
  function automatic logic [31:0] rv(input logic [3:0] i);
    return {4'h9, i, 8'h5a, 4'h3, i, 8'hc6};
  endfunction

  function automatic logic [31:0] mdat(input logic [31:0] a);
    return {~a[15:0], a[15:0] ^ 16'h8001};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_flag(input string nm, input logic e, input logic g);
    chk(nm, 32'(e), 32'(g));
  endtask

  task automatic cmp_mem(input mrm_note_t e);
    chk("note kind", 32'(e.r), 32'h0);
    chk("mem_we", 32'(e.we), 32'(mem_we));
    chk("mem_size", 32'(e.sz), 32'(mem_size));
    chk("mem_addr", e.a, mem_addr);
    if (e.we) chk("mem_wdata", e.d, mem_wdata);
  endtask

  task automatic cmp_reg(input mrm_note_t e);
    chk("note kind", 32'(e.r), 32'h1);
    chk("rf_waddr", e.a, 32'(rf_waddr));
    chk("rf_wdata", e.d, rf_wdata);
  endtask

  task automatic push(input logic r, input logic we, input logic [1:0] sz,
                      input logic [31:0] a, input logic [31:0] d);
    note_q.push_back('{r, we, sz, a, d});
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Driver
  // ------------------------------------------------------------------
  // Issues one start pulse and waits a bounded time for completion.
  task automatic go(input logic [15:0] op, input logic [15:0] ext,
                    input logic [31:0] ea, input logic leg, input logic bad);
    int n;
    n = 0;
    @(negedge mclk);
    op_word = op;
    ext_word = ext;
    ea_addr = ea;
    legacy_store = leg;
    slow = 1'($random(seed));
    start = 1'b1;
    @(negedge mclk);
    start = 1'b0;
    op_word = 16'($random(seed));
    ext_word = 16'($random(seed));
    ea_addr = $random(seed);
    cmp_flag("illegal", bad, illegal);
    cmp_flag("busy", !bad, busy);
    while (!bad && done !== 1'b1 && n < 400) begin
      @(negedge mclk);
      n++;
    end
    cmp_flag("done", 1'b1, bad || done === 1'b1);
    cmp_flag("busy at done", 1'b0, busy);
    @(negedge mclk);
    cmp_flag("all results seen", 1'b1, note_q.size() == 0);
  endtask

  // Multi-register move with random mask that always includes An itself.
  task automatic mrm(input logic dr, input logic sz, input logic [2:0] md,
                     input logic [2:0] rg, input logic leg);
    logic [15:0] mask;
    logic [31:0] a, a0, len, d, an;
    logic ok;
    int r;
    len = sz ? 32'h4 : 32'h2;
    an = rv({1'b1, rg});
    mask = 16'($random(seed));
    mask[md == 3'h4 ? 7 - rg : 8 + rg] = 1'b1;
    a = (md == 3'h3 || md == 3'h4) ? an : $random(seed);
    a0 = a;
    ok = dr ? (md inside {3'h2, 3'h3, 3'h5, 3'h6} || (md == 3'h7 && rg < 3'h4))
            : (md inside {3'h2, 3'h4, 3'h5, 3'h6} || (md == 3'h7 && rg < 3'h2));
    for (r = 0; ok && r < 16; r++) begin
      if (mask[r] && md == 3'h4) begin
        a -= len;
        d = (15 - r == 8 + rg) ? (leg ? an : an - len) : rv(4'(15 - r));
        push(1'b0, 1'b1, {sz, ~sz}, a, sz ? d : {16'h0, d[15:0]});
      end else if (mask[r] && !dr) begin
        d = rv(4'(r));
        push(1'b0, 1'b1, {sz, ~sz}, a, sz ? d : {16'h0, d[15:0]});
        a += len;
      end else if (mask[r]) begin
        d = mdat(a);
        push(1'b0, 1'b0, {sz, ~sz}, a, 32'h0);
        if (!(md == 3'h3 && r == 8 + rg))
          push(1'b1, 1'b0, 2'h0, r, sz ? d : {{16{d[15]}}, d[15:0]});
        a += len;
      end
    end
    if (ok && (md == 3'h3 || md == 3'h4))
      push(1'b1, 1'b0, 2'h0, {28'h0, 1'b1, rg}, a);
    go({4'h4, 1'b1, dr, 3'h1, sz, md, rg}, mask, a0, leg, !ok);
  endtask

  // Peripheral byte move: bytes at every second address, high byte first.
  task automatic pbm(input logic [1:0] opm, input logic [2:0] dn,
                     input logic [2:0] an, input logic [15:0] disp);
    logic [31:0] a, d, m;
    int k, n;
    n = opm[0] ? 4 : 2;
    a = rv({1'b1, an}) + {{16{disp[15]}}, disp};
    d = rv({1'b0, dn});
    for (k = 0; k < n; k++) begin
      m = mdat(a);
      push(1'b0, opm[1], 2'h0, a, {24'h0, d[8 * (n - 1 - k) +: 8]});
      if (!opm[1])
        d[8 * (n - 1 - k) +: 8] = m[7:0];
      a += 32'h2;
    end
    if (!opm[1])
      push(1'b1, 1'b0, 2'h0, {29'h0, dn}, d);
    go({4'h0, dn, 1'b1, opm, 3'h1, an}, disp, rv({1'b1, an}), 1'b0, 1'b0);
  endtask

  // ------------------------------------------------------------------
  // Clock, monitor, timeout and main sequence
  // ------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Each memory handshake or register write takes the oldest note.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      $display("wrong value cycle limit expected done seen hang");
      finish_test;
    end
    if (reset_n && mem_req === 1'b1 && mem_ready === 1'b1) begin
      if (note_q.size() == 0) chk("pending note", 32'h1, 32'h0);
      else cmp_mem(note_q.pop_front());
    end
    if (reset_n && rf_we === 1'b1) begin
      if (note_q.size() == 0) chk("pending note", 32'h1, 32'h0);
      else cmp_reg(note_q.pop_front());
    end
  end

  initial begin
    {reset_n, start, legacy_store, slow} = 4'h0;
    op_word = 16'h0;
    ext_word = 16'h0;
    ea_addr = 32'h0;
    repeat (10) @(negedge mclk);
    reset_n = 1'b1;
    for (i = 0; i < 48; i++) begin
      c = i % 12;
      mrm(1'(i / 12), 1'($random(seed)), c < 7 ? 3'(c) : 3'h7,
          c < 7 ? 3'($random(seed)) : 3'(c - 7), 1'(i / 24));
      if (c == 11) $display("multi move group %0d finished", i / 12);
    end
    for (i = 0; i < 8; i++)
      pbm(2'(i), 3'($random(seed)), 3'($random(seed)),
          16'($random(seed)) | (i > 3 ? 16'h8000 : 16'h0));
    $display("peripheral move test finished");
    finish_test;
  end
endmodule
`default_nettype wire
